//--- logic/async_sync2.sv
// Two-flip-flop synchroniser, vector wide, with reset level
`timescale 1ns/10ps
`default_nettype none
module async_sync2 #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge i_ref_clk or negedge i_resetn)
			begin
				if (!i_resetn)
				begin
					meta[g] <= RESET_VAL[g];
					o_sync[g] <= RESET_VAL[g];
				end
				else if (i_ce)
				begin
					meta[g] <= i_async[g];
					o_sync[g] <= meta[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

//--- logic/cpu_ctl_pins.sv
// Coprocessor handshake, non-maskable interrupt and reset pin control
`timescale 1ns/10ps
`default_nettype none
module cpu_ctl_pins (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_nmi,
	input wire logic i_ext_operand_req,
	input wire logic i_busy_n,
	input wire logic i_error_n,
	input wire logic i_hold_req,
	input wire logic i_intr_pending,
	input wire logic i_int_enable,
	input wire logic i_wait_instr,
	input wire logic i_coproc_opcode_instr,
	input wire logic i_intr_done,
	input wire logic i_operand_done,
	input wire logic i_protect_ok,
	output logic o_ext_operand_ack_n,
	output cpu_ctl_pkg::bus_pins_t o_bus,
	output logic o_hold_ack,
	output logic o_data_oe,
	output logic o_fetch_start,
	output logic o_stall,
	output logic o_protect_fault,
	output cpu_ctl_pkg::intr_req_t o_intr
);
	import cpu_ctl_pkg::*;

	logic [3:0] sync_out;
	logic nmi_s;
	logic req_s;
	logic busy_n_s;
	logic error_n_s;
	logic nmi_prev;
	logic req_block;
	logic nmi_pend;
	logic nmi_rise;
	logic [5:0] init_cnt;
	logic coproc_sync_instr;
	core_state_t state;
	core_state_t next_state;

	// Operand request is also async to this clock, so it is synchronised too
	async_sync2 #(
		.WIDTH(4),
		.RESET_VAL(4'hc)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_async({i_error_n, i_busy_n, i_ext_operand_req, i_nmi}),
		.o_sync(sync_out)
	);

	assign nmi_s = sync_out[0];
	assign req_s = sync_out[1];
	assign busy_n_s = sync_out[2];
	assign error_n_s = sync_out[3];

	assign nmi_rise = nmi_s && !nmi_prev;
	assign coproc_sync_instr = i_wait_instr || i_coproc_opcode_instr;

	// Edge history
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			nmi_prev <= 1'b0;
			req_block <= 1'b0;
		end
		else if (i_ce)
		begin
			nmi_prev <= nmi_s;
			// Synchroniser lag would retake a request already served
			if (state == ST_OPERAND)
			begin
				req_block <= 1'b1;
			end
			else if (!req_s)
			begin
				req_block <= 1'b0;
			end
		end
	end

	// Latched NMI; a new edge in the take cycle wins over the clear
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			nmi_pend <= 1'b0;
		end
		else if (i_ce)
		begin
			if (nmi_rise)
			begin
				nmi_pend <= 1'b1;
			end
			else if (state == ST_INTR && o_intr.take && o_intr.vector == NMI_VECTOR)
			begin
				nmi_pend <= 1'b0;
			end
		end
	end

	// Post-reset initialisation count
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			init_cnt <= 6'h00;
		end
		else if (i_ce && state == ST_INIT)
		begin
			init_cnt <= init_cnt + 6'h01;
		end
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_INIT:
			begin
				if (init_cnt == INIT_CNT_W1)
				begin
					next_state = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (nmi_pend || (i_intr_pending && i_int_enable))
				begin
					next_state = ST_INTR;
				end
				else if (req_s && !req_block)
				begin
					next_state = ST_OPERAND;
				end
				else if (coproc_sync_instr && (!busy_n_s || !error_n_s))
				begin
					next_state = !error_n_s ? ST_INTR : ST_STALL;
				end
			end
			ST_STALL:
			begin
				if (nmi_pend || (i_intr_pending && i_int_enable))
				begin
					next_state = ST_INTR;
				end
				else if (busy_n_s)
				begin
					next_state = ST_RUN;
				end
			end
			ST_OPERAND:
			begin
				if (i_operand_done || !i_protect_ok)
				begin
					next_state = ST_RUN;
				end
			end
			ST_INTR:
			begin
				if (i_intr_done)
				begin
					next_state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state <= ST_INIT;
		end
		else if (i_ce)
		begin
			state <= next_state;
		end
	end

	// Interrupt dispatch: pulse on entry to ST_INTR
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_intr <= '0;
		end
		else if (i_ce)
		begin
			o_intr.take <= 1'b0;
			if (state != ST_INTR && next_state == ST_INTR)
			begin
				o_intr.take <= 1'b1;
				if (nmi_pend)
				begin
					o_intr.vector <= NMI_VECTOR;
					o_intr.ack_cycles <= 1'b0;
				end
				else if (state == ST_RUN && !error_n_s && coproc_sync_instr
					&& !(i_intr_pending && i_int_enable))
				begin
					o_intr.vector <= EXT_ERR_VECTOR;
					o_intr.ack_cycles <= 1'b0;
				end
				else
				begin
					// Maskable interrupt: vector read by acknowledge cycles
					o_intr.vector <= 8'h00;
					o_intr.ack_cycles <= 1'b1;
				end
			end
		end
	end

	// Operand acknowledge and protection result
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_ext_operand_ack_n <= 1'b1;
			o_protect_fault <= 1'b0;
		end
		else if (i_ce)
		begin
			o_ext_operand_ack_n <= !(next_state == ST_OPERAND && i_protect_ok);
			o_protect_fault <= state == ST_OPERAND && !i_protect_ok;
		end
	end

	// Pin drive; reset levels come straight from the async reset
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_bus.status_line_zero_n <= 1'b1;
			o_bus.status_line_one_n <= 1'b1;
			o_bus.addr <= ADDR_RESET;
			o_bus.byte_high_enable_n <= 1'b1;
			o_bus.lock_n <= 1'b1;
			o_bus.mem_io_select <= 1'b0;
			o_bus.code_or_ack_select <= 1'b0;
			o_data_oe <= 1'b0;
			o_fetch_start <= 1'b0;
			o_stall <= 1'b0;
		end
		else if (i_ce)
		begin
			o_fetch_start <= state == ST_INIT && next_state == ST_RUN;
			o_stall <= next_state == ST_STALL;
			if (state == ST_INIT && next_state == ST_RUN)
			begin
				// First code fetch: memory read of code
				o_bus.status_line_zero_n <= 1'b0;
				o_bus.mem_io_select <= 1'b1;
				o_bus.code_or_ack_select <= 1'b1;
			end
			else
			begin
				o_bus.status_line_zero_n <= 1'b1;
			end
		end
	end

	// Hold ack low in reset whatever hold request does; sampled after release
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_hold_ack <= 1'b0;
		end
		else if (i_ce)
		begin
			o_hold_ack <= i_hold_req && state != ST_OPERAND;
		end
	end
endmodule
`default_nettype wire

//--- pkg/cpu_ctl_pkg.sv
// Constants and carrier types for the processor control-pin block
// Operation
// - A non-maskable interrupt takes handler vector 2 from an internal constant, not from the bus.
// - Servicing the non-maskable interrupt produces no interrupt acknowledge bus cycles.
// - The non-maskable interrupt is recognised whatever the interrupt enable flag says.
// - The asynchronous active-high non-maskable input is synchronised and then rising-edge detected.
// - An active-high operand request from the coprocessor starts a protected operand transfer.
// - The active-low operand acknowledge marks the cycle in which the operand moves on the bus.
// - While busy is low, wait and some coprocessor escape instructions stall until busy goes high; with error also low the code raises the error interrupt.
// - Interrupts are still accepted and serviced while stalled on busy.
// - An active error input at a wait or escape instruction raises the extension error interrupt.
// - Busy and error are active low, asynchronous, synchronised, and idle high when undriven.
// - System reset clears all internal state except the busy and error synchroniser stages, which load high.
// - In reset the status lines, acknowledge, address, byte-high and lock are high, select lines and hold ack low, data floats.
// - After reset falls, about 38 clocks of initialisation pass before the first code fetch.
// - Hold acknowledge is low in reset whatever the hold request input does.
package cpu_ctl_pkg;

	localparam int CLK_MHZ = 125;
	localparam int INIT_CLKS = 38;
	localparam int NMI_MIN_CLKS = 4;
	localparam logic [7:0] NMI_VECTOR = 8'h02;
	localparam logic [7:0] EXT_ERR_VECTOR = 8'h10;
	localparam logic [5:0] INIT_CNT_W1 = 6'h25;
	localparam logic [23:0] ADDR_RESET = 24'hffffff;

	typedef enum logic [2:0]
	{
		ST_INIT = 3'b000,
		ST_RUN = 3'b001,
		ST_STALL = 3'b010,
		ST_OPERAND = 3'b011,
		ST_INTR = 3'b100
	} core_state_t;

	// Pin-side bus outputs as one group
	typedef struct packed
	{
		logic status_line_zero_n;
		logic status_line_one_n;
		logic [23:0] addr;
		logic byte_high_enable_n;
		logic lock_n;
		logic mem_io_select;
		logic code_or_ack_select;
	} bus_pins_t;

	// Interrupt dispatch to the execution core
	typedef struct packed
	{
		logic take;
		logic [7:0] vector;
		logic ack_cycles;
	} intr_req_t;

endpackage

//--- tb/coproc_model.sv
// Coprocessor stand-in driving request, busy and error
`timescale 1ns/10ps
`default_nettype none
module coproc_model (
	input wire logic i_ref_clk,
	input wire logic i_ack_n,
	input wire logic i_start,
	input wire logic i_drop,
	input wire logic [3:0] i_busy_len,
	input wire logic i_err,
	output logic o_req,
	output logic o_busy_n,
	output logic o_error_n
);
	logic [3:0] left = 4'h0;
	initial
		o_req = 1'b0;
	// Held until the operand moves; drop covers a refused transfer
	always @(posedge i_ref_clk)
		if (i_start)
			o_req <= 1'b1;
		else if (!i_ack_n || i_drop)
			o_req <= 1'b0;
	always @(posedge i_ref_clk)
		if (i_busy_len != 4'h0)
			left <= i_busy_len;
		else if (left != 4'h0)
			left <= left - 4'h1;
	// Idle high, as the pull-ups leave them
	assign o_busy_n = (left == 4'h0);
	assign o_error_n = !i_err;
endmodule
`default_nettype wire

//--- tb/cpu_ctl_pins_asserts.sv
// Port checker for the control-pin block
`timescale 1ns/10ps
`default_nettype none
module cpu_ctl_pins_asserts
	import cpu_ctl_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_nmi,
	input wire logic i_ext_operand_req,
	input wire logic i_busy_n,
	input wire logic i_error_n,
	input wire logic i_hold_req,
	input wire logic o_ext_operand_ack_n,
	input wire bus_pins_t o_bus,
	input wire logic o_hold_ack,
	input wire logic o_data_oe,
	input wire logic o_fetch_start,
	input wire logic o_stall,
	input wire logic o_protect_fault,
	input wire intr_req_t o_intr
);
	logic [6:0] cnt;
	always_ff @(posedge i_ref_clk or negedge i_resetn)
		if (!i_resetn)
			cnt <= '0;
		else if (cnt != 7'h7f)
			cnt <= cnt + 7'h01;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);
	AST_RST_PINS: assert property (disable iff (1'b0)
		!i_resetn |-> o_bus == {2'b11, ADDR_RESET, 2'b11, 2'b00}
		&& o_ext_operand_ack_n && !o_data_oe)
		else $error("pin state wrong in reset");
	AST_HOLD_RST: assert property (disable iff (1'b0)
		!i_resetn && !i_hold_req |-> !o_hold_ack)
		else $error("hold ack high in reset");
	AST_NMI_VEC: assert property (
		o_intr.take && o_intr.vector == NMI_VECTOR |-> !o_intr.ack_cycles)
		else $error("nmi asks for ack cycles");
	AST_NMI_SYNC: assert property (
		o_intr.take && o_intr.vector == NMI_VECTOR |-> $past(i_nmi, 2))
		else $error("nmi taken without input");
	AST_ACK_REQ: assert property (
		$fell(o_ext_operand_ack_n) |-> $past(i_ext_operand_req, 2))
		else $error("ack without request");
	AST_FAULT: assert property (
		o_protect_fault |-> o_ext_operand_ack_n)
		else $error("ack given on fault");
	AST_STALL_END: assert property (
		i_busy_n [*4] |=> !o_stall)
		else $error("stall outlives busy");
	AST_ERR_VEC: assert property (
		o_intr.take && o_intr.vector == EXT_ERR_VECTOR |-> $past(!i_error_n, 2))
		else $error("error vector without error");
	AST_INIT: assert property (
		o_fetch_start |-> cnt == 7'h26)
		else $error("first fetch at wrong time");
endmodule
`default_nettype wire

//--- tb/cpu_ctl_pins_tb.sv
// Self-checking bench for the control-pin block
`timescale 1ns/10ps
`default_nettype none
module cpu_ctl_pins_tb;
	import cpu_ctl_pkg::*;
	// Reset starts released so its first fall is a real edge
	logic i_ref_clk = 1'b0, i_resetn = 1'b1, i_ce = 1'b1, i_nmi = 1'b0;
	logic i_hold_req = 1'b0, i_intr_pending = 1'b0, i_int_enable = 1'b0;
	logic i_wait_instr = 1'b0, i_coproc_opcode_instr = 1'b0;
	logic i_intr_done = 1'b0, i_operand_done = 1'b0, i_protect_ok = 1'b1;
	logic m_start = 1'b0, m_drop = 1'b0, m_err = 1'b0;
	logic [3:0] m_len = 4'h0;
	logic i_ext_operand_req, i_busy_n, i_error_n, o_ext_operand_ack_n;
	logic o_hold_ack, o_data_oe, o_fetch_start, o_stall, o_protect_fault;
	bus_pins_t o_bus;
	intr_req_t o_intr;
	int err_total = 0, n_compared = 0, cyc = 0;
	cpu_ctl_pins u_dut (.i_ref_clk, .i_resetn, .i_ce, .i_nmi,
		.i_ext_operand_req, .i_busy_n, .i_error_n, .i_hold_req,
		.i_intr_pending, .i_int_enable, .i_wait_instr, .i_coproc_opcode_instr,
		.i_intr_done, .i_operand_done, .i_protect_ok, .o_ext_operand_ack_n,
		.o_bus, .o_hold_ack, .o_data_oe, .o_fetch_start, .o_stall,
		.o_protect_fault, .o_intr);
	coproc_model u_cop (.i_ref_clk, .i_ack_n(o_ext_operand_ack_n),
		.i_start(m_start), .i_drop(m_drop), .i_busy_len(m_len),
		.i_err(m_err), .o_req(i_ext_operand_req), .o_busy_n(i_busy_n),
		.o_error_n(i_error_n));
	initial
		forever #4 i_ref_clk = ~i_ref_clk;
	task automatic close_out;
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_total++;
			close_out;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wtake(input logic [7:0] v);
		for (int k = 0; k < 20 && o_intr.take !== 1'b1; k++)
			@(negedge i_ref_clk);
		chk(o_intr.take, 1'b1);
		chk(o_intr.vector, v);
		chk(o_intr.ack_cycles, 1'b0);
		@(posedge i_ref_clk) i_intr_done <= 1'b1;
		@(posedge i_ref_clk) i_intr_done <= 1'b0;
	endtask
	task automatic nmi_pulse;
		@(posedge i_ref_clk) i_nmi <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		i_nmi <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
	endtask
	task automatic t_reset;
		int k;
		@(posedge i_ref_clk) i_resetn <= 1'b0;
		i_hold_req <= 1'b0;
		repeat (17) @(negedge i_ref_clk);
		chk(o_bus, {2'b11, ADDR_RESET, 4'hc});
		chk({o_ext_operand_ack_n, o_hold_ack, o_data_oe}, 3'h4);
		@(posedge i_ref_clk) i_resetn <= 1'b1;
		i_hold_req <= 1'b1;
		for (k = 0; k < 60 && o_fetch_start !== 1'b1; k++)
			@(negedge i_ref_clk);
		// Loop also counts the falling edge just after the release edge
		chk(k, INIT_CLKS + 1);
		chk({o_bus.status_line_zero_n, o_bus.mem_io_select,
			o_bus.code_or_ack_select}, 3'h3);
		chk(o_hold_ack, 1'b1);
		@(posedge i_ref_clk) i_hold_req <= 1'b0;
	endtask
	task automatic t_operand(input logic ok);
		@(posedge i_ref_clk) i_protect_ok <= ok;
		m_start <= 1'b1;
		@(posedge i_ref_clk) m_start <= 1'b0;
		repeat (4) @(negedge i_ref_clk);
		chk(o_ext_operand_ack_n, !ok);
		@(negedge i_ref_clk);
		chk(o_protect_fault, !ok);
		@(posedge i_ref_clk) i_operand_done <= ok;
		m_drop <= 1'b1;
		@(posedge i_ref_clk) i_operand_done <= 1'b0;
		m_drop <= 1'b0;
		repeat (2) @(negedge i_ref_clk);
		chk(o_ext_operand_ack_n, 1'b1);
	endtask
	initial
	begin
		t_reset;
		fork
			nmi_pulse;
			wtake(NMI_VECTOR);
		join
		t_operand(1'b1);
		t_operand(1'b0);
		@(posedge i_ref_clk) i_intr_pending <= 1'b1;
		i_int_enable <= 1'b1;
		repeat (2) @(negedge i_ref_clk);
		chk(o_intr.take, 1'b1);
		chk(o_intr.ack_cycles, 1'b1);
		@(posedge i_ref_clk) i_intr_pending <= 1'b0;
		i_int_enable <= 1'b0;
		i_intr_done <= 1'b1;
		@(posedge i_ref_clk) i_intr_done <= 1'b0;
		@(posedge i_ref_clk) i_wait_instr <= 1'b1;
		m_len <= 4'hf;
		@(posedge i_ref_clk) m_len <= 4'h0;
		repeat (5) @(negedge i_ref_clk);
		chk(o_stall, 1'b1);
		fork
			nmi_pulse;
			wtake(NMI_VECTOR);
		join
		repeat (12) @(negedge i_ref_clk);
		chk(o_stall, 1'b0);
		@(posedge i_ref_clk) m_err <= 1'b1;
		i_wait_instr <= 1'b0;
		i_coproc_opcode_instr <= 1'b1;
		wtake(EXT_ERR_VECTOR);
		@(posedge i_ref_clk) m_err <= 1'b0;
		i_coproc_opcode_instr <= 1'b0;
		t_reset;
		close_out;
	end
endmodule
bind cpu_ctl_pins cpu_ctl_pins_asserts u_chk (.i_ref_clk, .i_resetn, .i_nmi,
	.i_ext_operand_req, .i_busy_n, .i_error_n, .i_hold_req,
	.o_ext_operand_ack_n, .o_bus, .o_hold_ack, .o_data_oe, .o_fetch_start,
	.o_stall, .o_protect_fault, .o_intr);
`default_nettype wire
